// *** mac_status_pkg.sv ***
// Package for the MAC status and PHY management register block.
// Assumes an 8-bit CPU register port with byte offsets and a single system clock.
`default_nettype none
package mac_status_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h4D;
  localparam logic [7:0] ADDR_PHY_DATA_LOW = 8'h4E;
  localparam logic [7:0] ADDR_PHY_DATA_HIGH = 8'h4F;
  localparam logic [7:0] ADDR_PHY_MGMT_STATE = 8'h50;
  localparam logic [7:0] ADDR_RX_WPTR_LOW = 8'h51;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h4C;
  // ==========================================================
  // Event flag bit positions
  localparam int BIT_TX_DONE = 0;
  localparam int BIT_TX_CTRL = 1;
  localparam int BIT_RX_OVF = 2;
  localparam int BIT_RX_DONE = 3;
  localparam int BIT_RX_PAUSE = 4;
  localparam int BIT_RX_CTRL = 5;
  localparam int BIT_PHY_DONE = 6;
  localparam int BIT_TX_FAULT = 7;
  // ==========================================================
  // Management state bit positions
  localparam int BIT_BUSY = 7;
  localparam int BIT_LINK_FAIL = 6;
  localparam int BIT_INVALID = 5;
  // ==========================================================
  // Reset values and pointer granularity
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam int PTR_ZERO_BITS = 5;
  localparam int EVENT_COUNT = 8;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cpu_req_t;
  typedef struct packed {
    logic tx_fault;
    logic phy_done;
    logic rx_ctrl;
    logic rx_pause;
    logic rx_done;
    logic rx_ovf;
    logic tx_ctrl;
    logic tx_done;
  } mac_events_t;
  typedef struct packed {
    logic [15:0] data;
    logic done;
    logic link_fail;
    logic valid;
    logic [4:0] phy_addr;
  } phy_result_t;
  typedef enum logic [1:0] {MGMT_IDLE, MGMT_ONESHOT, MGMT_POLL} mgmt_state_t;
endpackage
`default_nettype wire

// *** event_flag_bit.sv ***
// One sticky event flag with write-one-to-clear and set priority.
// Assumes same-clock event and clear pulses.
`default_nettype none
module event_flag_bit (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic event_in,
  input wire logic clear_in,
  output logic flag
);
  // ==========================================================
  // Sticky flag, set wins over clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (event_in) begin
      flag <= 1'b1;
    end else if (clear_in) begin
      flag <= 1'b0;
    end
  end
endmodule // event_flag_bit
`default_nettype wire

// *** rx_pointer_track.sv ***
// Receive write pointer low byte, kept on 32-byte boundaries.
// Assumes reload and advance strobes from the receive DMA on the same clock.
`default_nettype none
module rx_pointer_track
  import mac_status_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reload,
  input wire logic [7:0] reload_value,
  input wire logic load_now,
  input wire logic [7:0] dma_value,
  output logic [7:0] ptr_low_ff
);
  // ==========================================================
  // Pointer register, low bits forced to zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ptr_low_ff <= RESET_BYTE;
    end else if (reload) begin
      ptr_low_ff <= {reload_value[7:PTR_ZERO_BITS], 5'h00};
    end else if (load_now) begin
      ptr_low_ff <= {dma_value[7:PTR_ZERO_BITS], 5'h00};
    end
  end
  a_ptr_aligned: assert property (@(posedge ref_clk) disable iff (rst)
    ptr_low_ff[4:0] == 5'h00) else $error("pointer low bits not zero");
  a_ptr_reload: assert property (@(posedge ref_clk) disable iff (rst)
    reload |=> ptr_low_ff[7:5] == $past(reload_value[7:5]))
    else $error("pointer not reloaded");
endmodule // rx_pointer_track
`default_nettype wire

// *** mac_status_regs.sv ***
// MAC event flags, PHY read data, PHY management state and receive pointer.
// Assumes a CPU port with one-cycle strobes, read data one cycle later,
// and event pulses from the MAC engines on ref_clk; PHY link status is async.
//
// Strobed register access was left to the implementer.
`default_nettype none
module mac_status_regs
  import mac_status_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire mac_status_pkg::cpu_req_t cpu_req,
  output logic [7:0] cpu_rdata_ff,
  input wire mac_status_pkg::mac_events_t mac_events,
  input wire mac_status_pkg::phy_result_t phy_result,
  input wire logic phy_link_fail_pin,
  input wire logic phy_read_command,
  input wire logic phy_write_command,
  input wire logic poll_enable,
  input wire logic soft_reset_bit,
  input wire logic rx_reset_bit,
  input wire logic [7:0] tx_low_boundary_ptr,
  input wire logic rx_ptr_update,
  input wire logic [7:0] rx_ptr_value,
  output logic rx_discard_ff,
  output logic sys_irq_ff,
  output logic rx_irq_ff,
  output logic tx_irq_ff
);
  logic [7:0] flags;
  logic [7:0] irq_enable_ff;
  logic [15:0] phy_read_data_ff;
  logic busy_ff;
  logic link_sync1_ff;
  logic link_sync2_ff;
  logic invalid_ff;
  logic [4:0] polled_phy_address_ff;
  logic [7:0] rx_wptr_low;
  logic clear_write;
  logic [7:0] gated;
  mgmt_state_t mgmt_ff;
  mgmt_state_t nxt_mgmt;

  // ==========================================================
  // Event flags
  assign clear_write = cpu_req.wr && (cpu_req.addr == ADDR_EVENT_FLAGS);
  genvar gi;
  generate
    for (gi = 0; gi < EVENT_COUNT; gi++) begin : g_flag
      event_flag_bit u_flag (
        .ref_clk(ref_clk),
        .rst(rst),
        .event_in(mac_events[gi]),
        .clear_in(clear_write && cpu_req.wdata[gi]),
        .flag(flags[gi])
      );
    end
  endgenerate

  // Each event sets its flag; a one written without an event clears it
  a_fault_flag_sets: assert property (@(posedge ref_clk) disable iff (rst)
    mac_events.tx_fault |=> flags[BIT_TX_FAULT])
    else $error("fault flag missing");
  a_rx_ctrl_sets: assert property (@(posedge ref_clk) disable iff (rst)
    mac_events.rx_ctrl |=> flags[BIT_RX_CTRL])
    else $error("receive control flag missing");
  a_pause_flag_sets: assert property (@(posedge ref_clk) disable iff (rst)
    mac_events.rx_pause |=> flags[BIT_RX_PAUSE])
    else $error("pause flag missing");
  a_rx_done_sets: assert property (@(posedge ref_clk) disable iff (rst)
    mac_events.rx_done |=> flags[BIT_RX_DONE])
    else $error("receive done flag missing");
  a_overflow_flag_sets: assert property (@(posedge ref_clk) disable iff (rst)
    mac_events.rx_ovf |=> flags[BIT_RX_OVF])
    else $error("overflow flag missing");
  a_tx_ctrl_sets: assert property (@(posedge ref_clk) disable iff (rst)
    mac_events.tx_ctrl |=> flags[BIT_TX_CTRL])
    else $error("transmit control flag missing");
  a_tx_done_sets: assert property (@(posedge ref_clk) disable iff (rst)
    mac_events.tx_done |=> flags[BIT_TX_DONE])
    else $error("transmit done flag missing");
  a_clear_by_one: assert property (@(posedge ref_clk) disable iff (rst)
    (clear_write && cpu_req.wdata[BIT_RX_OVF] && !mac_events.rx_ovf) |=> !flags[BIT_RX_OVF])
    else $error("flag not cleared by one");

  // ==========================================================
  // Interrupt enable register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_enable_ff <= RESET_BYTE;
    end else if (cpu_req.wr && cpu_req.addr == ADDR_IRQ_ENABLE) begin
      irq_enable_ff <= cpu_req.wdata;
    end
  end

  // Enabled flags grouped into system, receive and transmit lines
  assign gated = flags & irq_enable_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sys_irq_ff <= 1'b0;
      rx_irq_ff <= 1'b0;
      tx_irq_ff <= 1'b0;
    end else begin
      sys_irq_ff <= gated[BIT_TX_FAULT] | gated[BIT_PHY_DONE] | gated[BIT_RX_OVF];
      rx_irq_ff <= gated[BIT_RX_CTRL] | gated[BIT_RX_PAUSE] | gated[BIT_RX_DONE];
      tx_irq_ff <= gated[BIT_TX_CTRL] | gated[BIT_TX_DONE];
    end
  end

  // Group lines follow enabled flags only
  a_rx_irq_gated: assert property (@(posedge ref_clk) disable iff (rst)
    (gated[BIT_RX_CTRL] || gated[BIT_RX_PAUSE] || gated[BIT_RX_DONE]) |=> rx_irq_ff)
    else $error("receive interrupt missing");
  a_sys_irq_gated: assert property (@(posedge ref_clk) disable iff (rst)
    (gated[BIT_TX_FAULT] || gated[BIT_PHY_DONE] || gated[BIT_RX_OVF]) |=> sys_irq_ff)
    else $error("system interrupt missing");
  a_irq_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    (gated == 8'h00)
    |=> (!sys_irq_ff && !rx_irq_ff && !tx_irq_ff))
    else $error("interrupt without enabled flag");

  // ==========================================================
  // Receiver hold-off while overflow flag stands
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_discard_ff <= 1'b0;
    end else begin
      rx_discard_ff <= nxt_discard(flags[BIT_RX_OVF], mac_events.rx_ovf);
    end
  end
  function automatic logic nxt_discard(input logic flag, input logic ev);
    return flag | ev;
  endfunction

  // Receiver resumes once the overflow flag is gone
  a_discard_release: assert property (@(posedge ref_clk) disable iff (rst)
    (!flags[BIT_RX_OVF] && !mac_events.rx_ovf) |=> !rx_discard_ff)
    else $error("receiver held off without overflow");

  // ==========================================================
  // PHY read data capture
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phy_read_data_ff <= RESET_WORD;
    end else if (phy_result.done && phy_result.valid) begin
      phy_read_data_ff <= phy_result.data;
    end
  end

  // ==========================================================
  // Management busy tracking
  always_comb begin
    nxt_mgmt = mgmt_ff;
    unique case (mgmt_ff)
      MGMT_IDLE: begin
        if (poll_enable) begin
          nxt_mgmt = MGMT_POLL;
        end else if (phy_read_command || phy_write_command) begin
          nxt_mgmt = MGMT_ONESHOT;
        end
      end
      MGMT_ONESHOT: begin
        if (phy_result.done) begin
          nxt_mgmt = poll_enable ? MGMT_POLL : MGMT_IDLE;
        end
      end
      MGMT_POLL: begin
        if (!poll_enable) begin
          nxt_mgmt = MGMT_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mgmt_ff <= MGMT_IDLE;
    end else begin
      mgmt_ff <= nxt_mgmt;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_mgmt != MGMT_IDLE);
    end
  end

  // Busy follows commands, answers and the poll level
  a_busy_on_write: assert property (@(posedge ref_clk) disable iff (rst)
    (mgmt_ff == MGMT_IDLE && phy_write_command) |=> busy_ff)
    else $error("busy not raised on write");
  a_busy_clears: assert property (@(posedge ref_clk) disable iff (rst)
    (mgmt_ff == MGMT_ONESHOT && phy_result.done && !poll_enable) |=> !busy_ff)
    else $error("busy stuck after answer");
  a_poll_off_idle: assert property (@(posedge ref_clk) disable iff (rst)
    (mgmt_ff == MGMT_POLL && !poll_enable) |=> !busy_ff)
    else $error("busy stuck after polling");

  // ==========================================================
  // Link fail synchroniser
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link_sync1_ff <= 1'b0;
      link_sync2_ff <= 1'b0;
    end else begin
      link_sync1_ff <= phy_link_fail_pin;
      link_sync2_ff <= link_sync1_ff;
    end
  end

  // ==========================================================
  // Poll validity and polled address
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      invalid_ff <= 1'b0;
      polled_phy_address_ff <= 5'h00;
    end else begin
      if (phy_result.done) begin
        invalid_ff <= !phy_result.valid;
      end
      if (mgmt_ff == MGMT_POLL || phy_result.done) begin
        polled_phy_address_ff <= phy_result.phy_addr;
      end
    end
  end

  // Validity and address taken from each answer
  a_invalid_tracks: assert property (@(posedge ref_clk) disable iff (rst)
    phy_result.done |=> (invalid_ff == !$past(phy_result.valid)))
    else $error("validity bit wrong");
  a_address_tracks: assert property (@(posedge ref_clk) disable iff (rst)
    (mgmt_ff == MGMT_POLL || phy_result.done)
    |=> polled_phy_address_ff == $past(phy_result.phy_addr))
    else $error("polled address wrong");

  // ==========================================================
  // Receive write pointer
  rx_pointer_track u_ptr (
    .ref_clk(ref_clk),
    .rst(rst),
    .reload(soft_reset_bit || rx_reset_bit),
    .reload_value(tx_low_boundary_ptr),
    .load_now(rx_ptr_update),
    .dma_value(rx_ptr_value),
    .ptr_low_ff(rx_wptr_low)
  );

  // ==========================================================
  // Read data mux, unmapped reads return zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpu_rdata_ff <= RESET_BYTE;
    end else if (cpu_req.rd) begin
      unique case (cpu_req.addr)
        ADDR_IRQ_ENABLE: cpu_rdata_ff <= irq_enable_ff;
        ADDR_EVENT_FLAGS: cpu_rdata_ff <= flags;
        ADDR_PHY_DATA_LOW: cpu_rdata_ff <= phy_read_data_ff[7:0];
        ADDR_PHY_DATA_HIGH: cpu_rdata_ff <= phy_read_data_ff[15:8];
        ADDR_PHY_MGMT_STATE: cpu_rdata_ff <= {busy_ff, link_sync2_ff, invalid_ff,
          polled_phy_address_ff};
        ADDR_RX_WPTR_LOW: cpu_rdata_ff <= rx_wptr_low;
        default: cpu_rdata_ff <= RESET_BYTE;
      endcase
    end else begin
      cpu_rdata_ff <= RESET_BYTE;
    end
  end

  // Read data carries the addressed register
  a_ptr_readback: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_req.rd && cpu_req.addr == ADDR_RX_WPTR_LOW)
    |=> cpu_rdata_ff == $past(rx_wptr_low))
    else $error("pointer read wrong");
  a_data_low_read: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_req.rd && cpu_req.addr == ADDR_PHY_DATA_LOW)
    |=> cpu_rdata_ff == $past(phy_read_data_ff[7:0]))
    else $error("data low read wrong");
  a_data_high_read: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_req.rd && cpu_req.addr == ADDR_PHY_DATA_HIGH)
    |=> cpu_rdata_ff == $past(phy_read_data_ff[15:8]))
    else $error("data high read wrong");
  a_link_fail_read: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_req.rd && cpu_req.addr == ADDR_PHY_MGMT_STATE)
    |=> cpu_rdata_ff[BIT_LINK_FAIL] == $past(link_sync2_ff))
    else $error("link fail read wrong");
  a_invalid_read: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_req.rd && cpu_req.addr == ADDR_PHY_MGMT_STATE)
    |=> cpu_rdata_ff[BIT_INVALID] == $past(invalid_ff))
    else $error("validity read wrong");
  a_address_read: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_req.rd && cpu_req.addr == ADDR_PHY_MGMT_STATE)
    |=> cpu_rdata_ff[4:0] == $past(polled_phy_address_ff))
    else $error("address read wrong");
  a_busy_read: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_req.rd && cpu_req.addr == ADDR_PHY_MGMT_STATE)
    |=> cpu_rdata_ff[BIT_BUSY] == $past(busy_ff))
    else $error("busy read wrong");

  // ==========================================================
  // Checks
  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    (flags[BIT_TX_FAULT] && !clear_write) |=> flags[BIT_TX_FAULT])
    else $error("flag cleared without write");
  a_flag_set_wins: assert property (@(posedge ref_clk) disable iff (rst)
    (mac_events.rx_done && clear_write) |=> flags[BIT_RX_DONE])
    else $error("event lost under clear");
  a_zero_write_keeps: assert property (@(posedge ref_clk) disable iff (rst)
    (flags[BIT_TX_DONE] && clear_write && !cpu_req.wdata[BIT_TX_DONE])
    |=> flags[BIT_TX_DONE]) else $error("zero write cleared flag");
  a_phy_done_sets: assert property (@(posedge ref_clk) disable iff (rst)
    mac_events.phy_done |=> flags[BIT_PHY_DONE]) else $error("done flag missing");
  a_overflow_discard: assert property (@(posedge ref_clk) disable iff (rst)
    flags[BIT_RX_OVF] |=> rx_discard_ff) else $error("receiver not held off");
  a_irq_gated: assert property (@(posedge ref_clk) disable iff (rst)
    (gated[BIT_TX_DONE] || gated[BIT_TX_CTRL]) |=> tx_irq_ff)
    else $error("transmit interrupt missing");
  a_busy_on_cmd: assert property (@(posedge ref_clk) disable iff (rst)
    (mgmt_ff == MGMT_IDLE && phy_read_command) |=> busy_ff)
    else $error("busy not raised");
  a_busy_polling: assert property (@(posedge ref_clk) disable iff (rst)
    (mgmt_ff == MGMT_POLL && poll_enable) |=> busy_ff)
    else $error("busy dropped while polling");
  a_link_copy: assert property (@(posedge ref_clk) disable iff (rst)
    link_sync2_ff == $past(link_sync1_ff)) else $error("link copy wrong");
  a_data_capture: assert property (@(posedge ref_clk) disable iff (rst)
    (phy_result.done && phy_result.valid) |=> phy_read_data_ff == $past(phy_result.data))
    else $error("phy data not captured");
endmodule // mac_status_regs
`default_nettype wire

// *** phy_mgmt_model.sv ***
// Far-side PHY management responder for the status register bench.
// Assumes command pulses and a poll level on ref_clk; answers after lat cycles.
`default_nettype none
module phy_mgmt_model
  import mac_status_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic poll,
  input wire logic [7:0] lat,
  input wire logic [15:0] rdata,
  input wire logic ok,
  input wire logic [4:0] addr,
  output mac_status_pkg::phy_result_t res
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // ==========================================================
  // Answer timer; data and valid toggle while no answer is due
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      res <= '0;
    end else begin
      res.done <= 1'b0;
      res.data <= ~res.data;
      res.valid <= ~res.valid;
      res.phy_addr <= addr;
      if (cnt == 1) begin
        res.done <= 1'b1;
        res.data <= rdata;
        res.valid <= ok;
      end
      if (cnt > 1) cnt <= cnt - 1;
      else if (start || poll) cnt <= lat;
      else cnt <= 0;
    end
  end
endmodule // phy_mgmt_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the MAC status and PHY management registers.
// Assumes the PHY responder model and the package are compiled first.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import mac_status_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, ok = 1'b1, poll_enable = 1'b0;
  logic phy_link_fail_pin = 1'b0, phy_read_command = 1'b0, phy_write_command = 1'b0;
  logic soft_reset_bit = 1'b0, rx_reset_bit = 1'b0, rx_ptr_update = 1'b0;
  logic rx_discard_ff, sys_irq_ff, rx_irq_ff, tx_irq_ff;
  logic [7:0] tx_low_boundary_ptr = 8'h00, rx_ptr_value = 8'h00, cpu_rdata_ff, r, m;
  logic [7:0] m_flags = 8'h00, m_ien = 8'h00, m_ptr = 8'h00;
  logic [15:0] pdata = 16'h0000, m_data = 16'h0000;
  logic [4:0] paddr = 5'h00, m_addr = 5'h00;
  logic m_busy = 1'b0, m_inv = 1'b0, lf = 1'b0;
  logic [31:0] seed = 32'h00017EF7;
  cpu_req_t cpu_req = '0;
  mac_events_t mac_events = '0;
  phy_result_t phy_result;
  int failures = 0, n_checks = 0;
  always #5 ref_clk = ~ref_clk;
  mac_status_regs u_mac_status_regs (.ref_clk, .rst, .cpu_req, .cpu_rdata_ff, .mac_events,
    .phy_result, .phy_link_fail_pin, .phy_read_command, .phy_write_command, .poll_enable,
    .soft_reset_bit, .rx_reset_bit, .tx_low_boundary_ptr, .rx_ptr_update, .rx_ptr_value,
    .rx_discard_ff, .sys_irq_ff, .rx_irq_ff, .tx_irq_ff);
  phy_mgmt_model u_phy_mgmt_model (.ref_clk, .rst, .start(phy_read_command | phy_write_command),
    .poll(poll_enable), .lat(8'h06), .rdata(pdata), .ok, .addr(paddr), .res(phy_result));
  // ==========================================================
  // Helpers: random bytes, model state, comparison, bus cycles
  function automatic logic [7:0] nxt();
    seed = {seed[30:0], ^(seed & 32'h80200003)};
    return seed[7:0];
  endfunction
  function automatic logic [7:0] st();
    return {m_busy, lf, m_inv, m_addr};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cpu_req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    cpu_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge ref_clk);
    cpu_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    cpu_req <= '0;
    #1 chk(nm, cpu_rdata_ff, exp);
  endtask
  // Event pulses together with an optional clearing write
  task automatic evc(input logic [7:0] ev, input logic [7:0] clr);
    @(posedge ref_clk);
    mac_events <= ev;
    cpu_req <= '{ADDR_EVENT_FLAGS, clr, |clr, 1'b0};
    @(posedge ref_clk);
    mac_events <= '0;
    cpu_req <= '0;
    m_flags = (m_flags & ~clr) | ev;
    #1;
  endtask
  // One management command, waiting for the responder's answer
  task automatic phy_op(input bit wrt);
    int k;
    k = 0;
    @(posedge ref_clk);
    if (wrt) phy_write_command <= 1'b1;
    else phy_read_command <= 1'b1;
    @(posedge ref_clk);
    phy_write_command <= 1'b0;
    phy_read_command <= 1'b0;
    m_busy = 1'b1;
    rd(ADDR_PHY_MGMT_STATE, st(), "mgmt_busy");
    do begin
      @(posedge ref_clk);
      k++;
    end while (phy_result.done !== 1'b1 && k < 50);
    if (k >= 50) failures++;
    // Completion pulse from the management engine into the event inputs
    mac_events.phy_done <= 1'b1;
    @(posedge ref_clk);
    mac_events.phy_done <= 1'b0;
    @(posedge ref_clk);
    m_busy = 1'b0;
    m_inv = !ok;
    m_addr = paddr;
    m_flags[BIT_PHY_DONE] = 1'b1;
    if (ok) m_data = pdata;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 8'h4C; a <= 8'h52; a++) rd(a[7:0], 8'h00, "reset_value");
    rd(8'h60, 8'h00, "unmapped");
    for (int i = 0; i < EVENT_COUNT; i++) begin
      m = 8'h01 << i;
      m_ien = nxt();
      wr(ADDR_IRQ_ENABLE, m_ien);
      rd(ADDR_IRQ_ENABLE, m_ien, "irq_enable");
      evc(m, 8'h00);
      chk("discard", {7'h00, rx_discard_ff}, {7'h00, m_flags[2]});
      @(posedge ref_clk);
      #1 chk("sys_irq", {7'h00, sys_irq_ff}, {7'h00, |(m_flags & m_ien & 8'hC4)});
      chk("rx_irq", {7'h00, rx_irq_ff}, {7'h00, |(m_flags & m_ien & 8'h38)});
      chk("tx_irq", {7'h00, tx_irq_ff}, {7'h00, |(m_flags & m_ien & 8'h03)});
      wr(ADDR_EVENT_FLAGS, 8'h00);
      rd(ADDR_EVENT_FLAGS, m_flags, "flags_after_event");
      evc(m, m);
      rd(ADDR_EVENT_FLAGS, m_flags, "flags_set_wins");
      evc(8'h00, m);
      rd(ADDR_EVENT_FLAGS, m_flags, "flags_cleared");
      chk("discard_off", {7'h00, rx_discard_ff}, 8'h00);
    end
    pdata = {nxt(), nxt()};
    r = nxt();
    paddr = r[4:0];
    phy_op(1'b0);
    rd(ADDR_PHY_MGMT_STATE, st(), "mgmt_after_read");
    rd(ADDR_EVENT_FLAGS, m_flags, "mgmt_done_flag");
    rd(ADDR_PHY_DATA_LOW, m_data[7:0], "data_low");
    rd(ADDR_PHY_DATA_HIGH, m_data[15:8], "data_high");
    evc(8'h00, 8'hFF);
    ok = 1'b0;
    pdata = ~pdata;
    phy_op(1'b1);
    rd(ADDR_PHY_MGMT_STATE, st(), "mgmt_invalid");
    rd(ADDR_PHY_DATA_LOW, m_data[7:0], "data_kept");
    rd(ADDR_EVENT_FLAGS, m_flags, "mgmt_write_done");
    @(posedge ref_clk);
    phy_link_fail_pin <= 1'b1;
    lf = 1'b1;
    @(posedge ref_clk);
    poll_enable <= 1'b1;
    repeat (30) @(posedge ref_clk);
    m_busy = 1'b1;
    rd(ADDR_PHY_MGMT_STATE, st(), "poll_busy");
    @(posedge ref_clk);
    poll_enable <= 1'b0;
    repeat (12) @(posedge ref_clk);
    m_busy = 1'b0;
    rd(ADDR_PHY_MGMT_STATE, st(), "poll_off");
    wr(ADDR_RX_WPTR_LOW, 8'hFF);
    rd(ADDR_RX_WPTR_LOW, 8'h00, "rx_wptr_read_only");
    for (int j = 1; j < 8; j++) begin
      m = nxt();
      r = nxt();
      @(posedge ref_clk);
      rx_ptr_update <= j[0];
      soft_reset_bit <= j[1];
      rx_reset_bit <= j[2];
      rx_ptr_value <= m;
      tx_low_boundary_ptr <= r;
      @(posedge ref_clk);
      rx_ptr_update <= 1'b0;
      soft_reset_bit <= 1'b0;
      rx_reset_bit <= 1'b0;
      m_ptr = (j > 1) ? (r & 8'hE0) : (m & 8'hE0);
      rd(ADDR_RX_WPTR_LOW, m_ptr, "rx_wptr");
    end
    conclude();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    conclude();
  end
endmodule // testbench
`default_nettype wire
